//--- btx_exec.sv
// Execute unit for branch, skip, return, table-read and miscellaneous instructions
`timescale 1ns/10ps
// Operation
// - Jump loads target into PC, two cycles, flags untouched.
// - Zero-skip skips when byte is zero; copy form also loads accumulator.
// - Bit-test skip checks bit 0..7; skips on zero, or on one inverted.
// - Incr/decr-skip writes byte back, skips on zero, both penalties apply.
// - Accumulator forms put new value in accumulator, skip on zero.
// - Returns restore PC in two cycles; value form loads accumulator; call two.
// - Current-page table read fills byte and high latch, two cycles.
// - Last-page table read does the same from the final page.
// - Nibble exchange swaps in place; accumulator form writes accumulator.
// - Pre-clear instructions take one cycle; flags depend on actual clear.
// - Actual clear zeroes timeout and power-down flags, else they hold.
// - Writing PC low byte adds one instruction cycle of four clocks.
// - A taken skip adds one cycle; untaken keeps listed count.
// - Power-down executes in one cycle and updates both flags.
// - Call pushes address of next instruction in the same clock that loads target.
// - Plain watchdog clear resets count and clears both flags.
// - Pre-clears clear the watchdog only once both have run; one just records itself.
// - Power-down halts, clears watchdog and prescaler, sets pd, clears timeout.
module btx_exec
  import btx_pkg::*;
#(
  parameter int DMEM_DEPTH = 64
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Instruction request
  input wire logic instr_valid,
  input wire btx_pkg::btx_op_t instr_op,
  input wire logic [btx_pkg::DADDR_W-1:0] instr_addr,
  input wire logic [2:0] instr_bit,
  input wire logic [7:0] instr_imm,
  input wire logic [btx_pkg::PC_W-1:0] instr_target,
  input wire logic [7:0] table_ptr,
  output logic instr_ready,
  output logic instr_done,
  output logic skip_taken,
  // Program memory table port
  output logic [btx_pkg::PC_W-1:0] rom_addr,
  input wire logic [btx_pkg::ROM_W-1:0] rom_data,
  // Watchdog and power
  input wire logic wdt_timeout,
  input wire logic wake,
  output logic wdt_clear,
  output logic halted,
  output logic timeout_flag,
  output logic power_down_flag,
  // Core state
  output logic [btx_pkg::PC_W-1:0] pc,
  output logic [7:0] accumulator,
  output logic [btx_pkg::TABLE_HIGH_LATCH_W-1:0] table_high_latch
);
  import btx_pkg::*;

  logic [7:0] dmem [DMEM_DEPTH];
  btx_state_t state_ff, nxt_state;
  btx_op_t op_ff;
  logic [DADDR_W-1:0] addr_ff;
  logic [2:0] bit_ff;
  logic [7:0] imm_ff;
  logic [PC_W-1:0] target_ff, stack_ff, pc_ff, rom_addr_ff;
  logic [CNT_W-1:0] clk_cnt_ff;
  logic [1:0] icyc_ff;
  logic [7:0] acc_ff;
  logic [TABLE_HIGH_LATCH_W-1:0] table_high_latch_ff;
  logic to_ff, pdf_ff, pre1_ff, pre2_ff, wdt_clear_ff, done_ff, skip_ff, ready_ff, halt_ff;

  // Operand fetch; the PC low byte is visible as a data byte
  wire logic [7:0] mval = (addr_ff == PCL_ADDR) ? pc_ff[7:0] : dmem[addr_ff];
  wire logic [7:0] m_inc = 8'(mval + 8'h01);
  wire logic [7:0] m_dec = 8'(mval - 8'h01);
  wire logic [7:0] m_swap = {mval[3:0], mval[7:4]};
  wire logic sel_bit = mval[bit_ff];

  wire logic accept = ready_ff & instr_valid;

  // Skip decision
  wire logic skip = ((op_ff == BTX_SKIP_ON_ZERO) && (mval == 8'h00)) ||
                    ((op_ff == BTX_SKIP_ON_ZERO_COPY_ACC) && (mval == 8'h00)) ||
                    ((op_ff == BTX_SKIP_ON_BIT_CLEAR) && !sel_bit) ||
                    ((op_ff == BTX_SKIP_ON_BIT_SET) && sel_bit) ||
                    ((op_ff == BTX_INCR_SKIP_ZERO) && (m_inc == 8'h00)) ||
                    ((op_ff == BTX_DECR_SKIP_ZERO) && (m_dec == 8'h00)) ||
                    ((op_ff == BTX_INCR_SKIP_ZERO_TO_ACC) && (m_inc == 8'h00)) ||
                    ((op_ff == BTX_DECR_SKIP_ZERO_TO_ACC) && (m_dec == 8'h00));

  // Data byte write-back
  wire logic is_tab = (op_ff == BTX_TABLE_READ_CURRENT_PAGE) ||
                      (op_ff == BTX_TABLE_READ_LAST_PAGE);
  wire logic wr_mem = (op_ff == BTX_INCR_SKIP_ZERO) || (op_ff == BTX_DECR_SKIP_ZERO) ||
                      (op_ff == BTX_BYTE_CLEAR) || (op_ff == BTX_BYTE_SET) ||
                      (op_ff == BTX_NIBBLE_EXCHANGE) || is_tab;
  wire logic [7:0] wr_val =
    (op_ff == BTX_INCR_SKIP_ZERO) ? m_inc :
    (op_ff == BTX_DECR_SKIP_ZERO) ? m_dec :
    (op_ff == BTX_BYTE_CLEAR) ? 8'h00 :
    (op_ff == BTX_BYTE_SET) ? 8'hFF :
    (op_ff == BTX_NIBBLE_EXCHANGE) ? m_swap :
    rom_data[7:0];
  wire logic wr_pcl = wr_mem && (addr_ff == PCL_ADDR);

  // Cycle count: listed base plus the two penalties
  wire logic two_base = (op_ff == BTX_JUMP_ALWAYS) || (op_ff == BTX_SUBROUTINE_CALL) ||
                        (op_ff == BTX_SUBROUTINE_RETURN) || (op_ff == BTX_RETURN_WITH_VALUE) ||
                        (op_ff == BTX_INTERRUPT_RETURN) || is_tab;
  wire logic [1:0] total_cyc = (two_base ? TWO_CYC : ONE_CYC) +
                               {1'b0, wr_pcl} +
                               {1'b0, skip};
  wire logic in_last_clk = (state_ff == BTX_RUN) &&
                           (clk_cnt_ff == CLKS_PER_ICYC - 4'h1) && (icyc_ff == total_cyc);
  wire logic commit = (state_ff == BTX_RUN) & in_last_clk;

  // Program counter update
  wire logic [PC_W-1:0] pc_seq = PC_W'(pc_ff + (skip ? 10'h002 : 10'h001));
  wire logic is_ret = (op_ff == BTX_SUBROUTINE_RETURN) || (op_ff == BTX_RETURN_WITH_VALUE) ||
                      (op_ff == BTX_INTERRUPT_RETURN);
  wire logic [PC_W-1:0] nxt_pc =
    ((op_ff == BTX_JUMP_ALWAYS) || (op_ff == BTX_SUBROUTINE_CALL)) ? target_ff :
    is_ret ? stack_ff :
    wr_pcl ? {pc_ff[PC_W-1:8], wr_val} :
    pc_seq;

  // Accumulator update
  wire logic acc_wr = (op_ff == BTX_SKIP_ON_ZERO_COPY_ACC) ||
                      (op_ff == BTX_INCR_SKIP_ZERO_TO_ACC) ||
                      (op_ff == BTX_DECR_SKIP_ZERO_TO_ACC) ||
                      (op_ff == BTX_RETURN_WITH_VALUE) || (op_ff == BTX_NIBBLE_EXCHANGE_TO_ACC);
  wire logic [7:0] nxt_acc =
    (op_ff == BTX_SKIP_ON_ZERO_COPY_ACC) ? mval :
    (op_ff == BTX_INCR_SKIP_ZERO_TO_ACC) ? m_inc :
    (op_ff == BTX_DECR_SKIP_ZERO_TO_ACC) ? m_dec :
    (op_ff == BTX_RETURN_WITH_VALUE) ? imm_ff :
    m_swap;

  // Watchdog clear decision; a repeated same pre-clear never completes the pair
  wire logic pre1_now = commit && (op_ff == BTX_WATCHDOG_PRECLEAR_FIRST);
  wire logic pre2_now = commit && (op_ff == BTX_WATCHDOG_PRECLEAR_SECOND);
  wire logic pair_done = (pre1_now && pre2_ff) || (pre2_now && pre1_ff);
  wire logic plain_clr = commit && (op_ff == BTX_WATCHDOG_CLEAR);
  wire logic pdown = commit && (op_ff == BTX_POWER_DOWN);
  wire logic wdt_clr_now = plain_clr || pair_done || pdown;
  wire logic flags_clr = plain_clr || pair_done;

  // Timeout from the watchdog wins over any clear in the same clock
  wire logic nxt_to = wdt_timeout ? 1'b1 : ((flags_clr || pdown) ? 1'b0 : to_ff);
  wire logic nxt_pdf = pdown ? 1'b1 : (flags_clr ? 1'b0 : pdf_ff);

  wire logic [PC_W-1:0] tab_addr = (instr_op == BTX_TABLE_READ_LAST_PAGE) ?
                                   {LAST_PAGE, table_ptr} :
                                   {pc_ff[PC_W-1:8], table_ptr};

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      BTX_IDLE: if (accept) nxt_state = BTX_RUN;
      BTX_RUN: if (commit) nxt_state = pdown ? BTX_HALTED : BTX_DONE;
      BTX_DONE: nxt_state = BTX_IDLE;
      BTX_HALTED: if (wake) nxt_state = BTX_IDLE;
      default: nxt_state = BTX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_ff <= BTX_IDLE;
      clk_cnt_ff <= '0;
      icyc_ff <= ONE_CYC;
    end else begin
      state_ff <= nxt_state;
      if (accept || (state_ff != BTX_RUN)) begin
        clk_cnt_ff <= '0;
        icyc_ff <= ONE_CYC;
      end else if (clk_cnt_ff == CLKS_PER_ICYC - 4'h1) begin
        clk_cnt_ff <= '0;
        icyc_ff <= 2'(icyc_ff + 2'h1);
      end else begin
        clk_cnt_ff <= 4'(clk_cnt_ff + 4'h1);
      end
    end
  end

  // Latched instruction fields
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      op_ff <= BTX_NO_OPERATION;
      addr_ff <= '0;
      bit_ff <= '0;
      imm_ff <= '0;
      target_ff <= PC_RST;
      rom_addr_ff <= PC_RST;
    end else if (accept) begin
      op_ff <= instr_op;
      addr_ff <= instr_addr;
      bit_ff <= instr_bit;
      imm_ff <= instr_imm;
      target_ff <= instr_target;
      rom_addr_ff <= tab_addr;
    end
  end

  // Architectural state
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pc_ff <= PC_RST;
      stack_ff <= PC_RST;
      acc_ff <= ACC_RST;
      table_high_latch_ff <= TABLE_HIGH_LATCH_RST;
    end else if (commit) begin
      pc_ff <= nxt_pc;
      if (op_ff == BTX_SUBROUTINE_CALL) stack_ff <= PC_W'(pc_ff + 10'h001);
      if (acc_wr) acc_ff <= nxt_acc;
      if (is_tab) table_high_latch_ff <= rom_data[ROM_W-1:8];
    end
  end

  // Data memory has no reset; software initialises it
  always_ff @(posedge sys_clk) begin
    if (commit && wr_mem && (addr_ff != PCL_ADDR)) dmem[addr_ff] <= wr_val;
  end

  // Flags and pre-clear bookkeeping
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      to_ff <= 1'b0;
      pdf_ff <= 1'b0;
      pre1_ff <= 1'b0;
      pre2_ff <= 1'b0;
      wdt_clear_ff <= 1'b0;
    end else begin
      to_ff <= nxt_to;
      pdf_ff <= nxt_pdf;
      pre1_ff <= (pair_done || wdt_clr_now) ? 1'b0 : (pre1_ff || pre1_now);
      pre2_ff <= (pair_done || wdt_clr_now) ? 1'b0 : (pre2_ff || pre2_now);
      wdt_clear_ff <= wdt_clr_now;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      done_ff <= 1'b0;
      skip_ff <= 1'b0;
      ready_ff <= 1'b0;
      halt_ff <= 1'b0;
    end else begin
      done_ff <= commit;
      skip_ff <= commit & skip;
      ready_ff <= (nxt_state == BTX_IDLE) && !accept;
      halt_ff <= (nxt_state == BTX_HALTED);
    end
  end

  assign instr_ready = ready_ff;
  assign instr_done = done_ff;
  assign skip_taken = skip_ff;
  assign rom_addr = rom_addr_ff;
  assign wdt_clear = wdt_clear_ff;
  assign halted = halt_ff;
  assign timeout_flag = to_ff;
  assign power_down_flag = pdf_ff;
  assign pc = pc_ff;
  assign accumulator = acc_ff;
  assign table_high_latch = table_high_latch_ff;
endmodule

//--- btx_pkg.sv
// Package for the branch, table-read and miscellaneous instruction execute unit
package btx_pkg;
  localparam int PC_W = 10;
  localparam int DADDR_W = 6;
  localparam int ROM_W = 14;
  localparam int TABLE_HIGH_LATCH_W = ROM_W - 8;
  localparam int CNT_W = 4;

  // One instruction cycle is four system clocks
  localparam logic [CNT_W-1:0] CLKS_PER_ICYC = 4'h4;
  localparam logic [1:0] ONE_CYC = 2'h1;
  localparam logic [1:0] TWO_CYC = 2'h2;

  // Data address at which the program-counter low byte appears
  localparam logic [DADDR_W-1:0] PCL_ADDR = 6'h06;

  // Reset values and the last program page
  localparam logic [PC_W-1:0] PC_RST = 10'h000;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [TABLE_HIGH_LATCH_W-1:0] TABLE_HIGH_LATCH_RST = 6'h00;
  localparam logic [PC_W-1:8] LAST_PAGE = 2'h3;

  typedef enum logic [4:0] {
    BTX_NO_OPERATION            = 5'h00,
    BTX_JUMP_ALWAYS             = 5'h01,
    BTX_SKIP_ON_ZERO            = 5'h02,
    BTX_SKIP_ON_ZERO_COPY_ACC   = 5'h03,
    BTX_SKIP_ON_BIT_CLEAR       = 5'h04,
    BTX_SKIP_ON_BIT_SET         = 5'h05,
    BTX_INCR_SKIP_ZERO          = 5'h06,
    BTX_DECR_SKIP_ZERO          = 5'h07,
    BTX_INCR_SKIP_ZERO_TO_ACC   = 5'h08,
    BTX_DECR_SKIP_ZERO_TO_ACC   = 5'h09,
    BTX_SUBROUTINE_CALL         = 5'h0A,
    BTX_SUBROUTINE_RETURN       = 5'h0B,
    BTX_RETURN_WITH_VALUE       = 5'h0C,
    BTX_INTERRUPT_RETURN        = 5'h0D,
    BTX_TABLE_READ_CURRENT_PAGE = 5'h0E,
    BTX_TABLE_READ_LAST_PAGE    = 5'h0F,
    BTX_BYTE_CLEAR              = 5'h10,
    BTX_BYTE_SET                = 5'h11,
    BTX_WATCHDOG_CLEAR          = 5'h12,
    BTX_WATCHDOG_PRECLEAR_FIRST = 5'h13,
    BTX_WATCHDOG_PRECLEAR_SECOND = 5'h14,
    BTX_NIBBLE_EXCHANGE         = 5'h15,
    BTX_NIBBLE_EXCHANGE_TO_ACC  = 5'h16,
    BTX_POWER_DOWN              = 5'h17
  } btx_op_t;

  // Gray-coded along idle -> run -> done (done -> idle flips both bits); halted sits beside done
  typedef enum logic [1:0] {
    BTX_IDLE   = 2'b00,
    BTX_RUN    = 2'b01,
    BTX_DONE   = 2'b11,
    BTX_HALTED = 2'b10
  } btx_state_t;
endpackage

//--- btx_exec_checker.sv
// Concurrent checks on the ports of the execute unit
`timescale 1ns/10ps
module btx_exec_checker
  import btx_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Instruction port
  input wire logic instr_valid,
  input wire btx_pkg::btx_op_t instr_op,
  input wire logic [btx_pkg::PC_W-1:0] instr_target,
  input wire logic [7:0] table_ptr,
  input wire logic instr_ready,
  input wire logic instr_done,
  input wire logic skip_taken,
  // Table, watchdog and core state
  input wire logic [btx_pkg::PC_W-1:0] rom_addr,
  input wire logic wdt_timeout,
  input wire logic wdt_clear,
  input wire logic halted,
  input wire logic timeout_flag,
  input wire logic power_down_flag,
  input wire logic [btx_pkg::PC_W-1:0] pc
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire taken = instr_ready && instr_valid;
  wire [PC_W-1:0] cur_page_addr = {pc[PC_W-1:8], table_ptr};
  sequence s_one_cyc;
    !instr_done [*4] ##1 instr_done;
  endsequence
  sequence s_two_cyc;
    !instr_done [*8] ##1 instr_done;
  endsequence
  sequence s_no_timeout;
    !wdt_timeout [*4];
  endsequence
  // PC is checked at the done cycle, nine samples after the accept
  a_branch_loads_pc: assert property (taken && instr_op inside {BTX_JUMP_ALWAYS,
    BTX_SUBROUTINE_CALL} |=> s_two_cyc ##0 (pc == $past(instr_target, 9)))
    else $error("jump or call timing or target wrong");
  a_return_two_cyc: assert property (taken && instr_op inside {BTX_SUBROUTINE_RETURN,
    BTX_RETURN_WITH_VALUE, BTX_INTERRUPT_RETURN} |=> s_two_cyc)
    else $error("return did not finish in two cycles");
  a_single_cyc_ops: assert property (taken && instr_op inside {BTX_NO_OPERATION,
    BTX_WATCHDOG_PRECLEAR_FIRST, BTX_WATCHDOG_PRECLEAR_SECOND, BTX_WATCHDOG_CLEAR,
    BTX_NIBBLE_EXCHANGE_TO_ACC, BTX_POWER_DOWN} |=> s_one_cyc)
    else $error("single-cycle instruction took the wrong time");
  a_skip_with_done: assert property (skip_taken |-> instr_done)
    else $error("skip pulse outside the done cycle");
  a_last_page_addr: assert property (taken && instr_op == BTX_TABLE_READ_LAST_PAGE
    |=> rom_addr[PC_W-1:8] == LAST_PAGE && rom_addr[7:0] == $past(table_ptr))
    else $error("last-page table address wrong");
  a_cur_page_addr: assert property (taken && instr_op == BTX_TABLE_READ_CURRENT_PAGE
    |=> rom_addr == $past(cur_page_addr))
    else $error("current-page table address wrong");
  a_plain_clear: assert property (taken && instr_op == BTX_WATCHDOG_CLEAR ##1 s_no_timeout
    |=> wdt_clear && !timeout_flag && !power_down_flag)
    else $error("plain watchdog clear missed flags or pulse");
  a_halt_flags: assert property ($rose(halted) && !$past(wdt_timeout)
    |-> power_down_flag && !timeout_flag && wdt_clear)
    else $error("power-down entry flags wrong");
  a_halt_no_accept: assert property (halted |-> !instr_ready)
    else $error("ready raised while halted");
endmodule

bind btx_exec btx_exec_checker u_chk (.sys_clk(sys_clk), .resetn(resetn),
  .instr_valid(instr_valid), .instr_op(instr_op), .instr_target(instr_target),
  .table_ptr(table_ptr), .instr_ready(instr_ready), .instr_done(instr_done),
  .skip_taken(skip_taken), .rom_addr(rom_addr), .wdt_timeout(wdt_timeout),
  .wdt_clear(wdt_clear), .halted(halted), .timeout_flag(timeout_flag),
  .power_down_flag(power_down_flag), .pc(pc));

//--- btx_testbench.sv
// Self-checking bench for the branch, table-read and miscellaneous execute unit
`timescale 1ns/10ps
module testbench;
  import btx_pkg::*;
  localparam logic [5:0] M = 6'h05;
  logic sys_clk, resetn, instr_valid, wdt_timeout, wake, saw_clear;
  btx_op_t instr_op;
  logic [DADDR_W-1:0] instr_addr;
  logic [2:0] instr_bit;
  logic [7:0] instr_imm, table_ptr, accumulator;
  logic [PC_W-1:0] instr_target, rom_addr, pc;
  logic instr_ready, instr_done, skip_taken, wdt_clear, halted, timeout_flag, power_down_flag;
  logic [TABLE_HIGH_LATCH_W-1:0] table_high_latch;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  // Program word tied to its address so page and pointer errors show up
  wire [ROM_W-1:0] rom_data = {rom_addr[9:8], rom_addr[3:0], rom_addr[7:0]};

  btx_exec uut (.sys_clk(sys_clk), .resetn(resetn), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_addr(instr_addr), .instr_bit(instr_bit),
    .instr_imm(instr_imm), .instr_target(instr_target), .table_ptr(table_ptr),
    .instr_ready(instr_ready), .instr_done(instr_done), .skip_taken(skip_taken),
    .rom_addr(rom_addr), .rom_data(rom_data), .wdt_timeout(wdt_timeout), .wake(wake),
    .wdt_clear(wdt_clear), .halted(halted), .timeout_flag(timeout_flag),
    .power_down_flag(power_down_flag), .pc(pc), .accumulator(accumulator),
    .table_high_latch(table_high_latch));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // A hang shows up as a cycle count far beyond the whole sequence
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches = mismatches + 1;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // One instruction: accept, then count clocks to the done pulse
  task automatic run(input btx_op_t op, input logic [5:0] a, input logic [9:0] v,
      input int n, input logic sk);
    int cnt;
    cnt = 0;
    @(negedge sys_clk);
    while (!instr_ready) @(negedge sys_clk);
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr_op <= op;
    instr_addr <= a;
    instr_target <= v;
    instr_imm <= v[7:0];
    table_ptr <= v[7:0];
    instr_bit <= v[2:0];
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    do begin
      @(negedge sys_clk);
      cnt++;
    end while (!instr_done && cnt < 20);
    chk("cycles", 16'(4 * n + 1), 16'(cnt));
    chk("skip", 16'(sk), 16'(skip_taken));
    saw_clear = wdt_clear;
  endtask

  task automatic pulse_timeout();
    @(posedge sys_clk);
    wdt_timeout <= 1'b1;
    @(posedge sys_clk);
    wdt_timeout <= 1'b0;
    @(negedge sys_clk);
    chk("timeout_flag", 16'h0001, 16'(timeout_flag));
  endtask

  task automatic t_branch();
    run(BTX_JUMP_ALWAYS, M, 10'h2A5, 2, 1'b0);
    run(BTX_SUBROUTINE_CALL, M, 10'h123, 2, 1'b0);
    chk("pc", 16'h0123, 16'(pc));
    run(BTX_RETURN_WITH_VALUE, M, 10'h05C, 2, 1'b0);
    chk("pc", 16'h02A6, 16'(pc));
    chk("acc", 16'h005C, 16'(accumulator));
    run(BTX_SUBROUTINE_CALL, M, 10'h300, 2, 1'b0);
    run(BTX_INTERRUPT_RETURN, M, 10'h000, 2, 1'b0);
    chk("pc", 16'h02A7, 16'(pc));
    run(BTX_SUBROUTINE_CALL, M, 10'h010, 2, 1'b0);
    run(BTX_SUBROUTINE_RETURN, M, 10'h000, 2, 1'b0);
    chk("pc", 16'h02A8, 16'(pc));
    $display("test branch done");
  endtask

  task automatic t_skips();
    run(BTX_BYTE_CLEAR, M, 10'h000, 1, 1'b0);
    run(BTX_SKIP_ON_ZERO_COPY_ACC, M, 10'h000, 2, 1'b1);
    chk("acc", 16'h0000, 16'(accumulator));
    run(BTX_BYTE_SET, M, 10'h000, 1, 1'b0);
    run(BTX_SKIP_ON_ZERO, M, 10'h000, 1, 1'b0);
    run(BTX_SKIP_ON_ZERO_COPY_ACC, M, 10'h000, 1, 1'b0);
    chk("acc", 16'h00FF, 16'(accumulator));
    run(BTX_INCR_SKIP_ZERO, M, 10'h000, 2, 1'b1);
    run(BTX_DECR_SKIP_ZERO_TO_ACC, M, 10'h000, 1, 1'b0);
    chk("acc", 16'h00FF, 16'(accumulator));
    run(BTX_BYTE_SET, M, 10'h000, 1, 1'b0);
    run(BTX_INCR_SKIP_ZERO_TO_ACC, M, 10'h000, 2, 1'b1);
    run(BTX_DECR_SKIP_ZERO, M, 10'h000, 1, 1'b0);
    // Byte is now 8'hFE: bit 0 clear, bit 7 set
    run(BTX_SKIP_ON_BIT_CLEAR, M, 10'h000, 2, 1'b1);
    run(BTX_SKIP_ON_BIT_CLEAR, M, 10'h007, 1, 1'b0);
    run(BTX_SKIP_ON_BIT_SET, M, 10'h007, 2, 1'b1);
    run(BTX_SKIP_ON_BIT_SET, M, 10'h000, 1, 1'b0);
    run(BTX_NIBBLE_EXCHANGE, M, 10'h000, 1, 1'b0);
    run(BTX_NIBBLE_EXCHANGE_TO_ACC, M, 10'h000, 1, 1'b0);
    chk("acc", 16'h00FE, 16'(accumulator));
    run(BTX_SKIP_ON_ZERO_COPY_ACC, M, 10'h000, 1, 1'b0);
    chk("acc", 16'h00EF, 16'(accumulator));
    $display("test skips done");
  endtask

  task automatic t_pcl_table();
    run(BTX_BYTE_CLEAR, 6'h06, 10'h000, 2, 1'b0);
    chk("pc", 16'h0200, 16'(pc));
    run(BTX_NO_OPERATION, M, 10'h000, 1, 1'b0);
    chk("pc", 16'h0201, 16'(pc));
    // Current-page read while still on page 2, so it cannot pass as a last-page read
    run(BTX_TABLE_READ_CURRENT_PAGE, M, 10'h000, 2, 1'b0);
    chk("table_high_latch", 16'h0020, 16'(table_high_latch));
    run(BTX_SKIP_ON_ZERO, M, 10'h000, 2, 1'b1);
    run(BTX_BYTE_SET, 6'h06, 10'h000, 2, 1'b0);
    chk("pc", 16'h02FF, 16'(pc));
    run(BTX_TABLE_READ_LAST_PAGE, M, 10'h044, 2, 1'b0);
    chk("table_high_latch", 16'h0034, 16'(table_high_latch));
    run(BTX_SKIP_ON_ZERO_COPY_ACC, M, 10'h000, 1, 1'b0);
    chk("acc", 16'h0044, 16'(accumulator));
    $display("test pcl and table done");
  endtask

  task automatic t_watchdog();
    pulse_timeout();
    run(BTX_WATCHDOG_PRECLEAR_FIRST, M, 10'h000, 1, 1'b0);
    run(BTX_WATCHDOG_PRECLEAR_FIRST, M, 10'h000, 1, 1'b0);
    chk("timeout_flag", 16'h0001, 16'(timeout_flag));
    run(BTX_WATCHDOG_PRECLEAR_SECOND, M, 10'h000, 1, 1'b0);
    chk("wdt_clear", 16'h0001, 16'(saw_clear));
    chk("timeout_flag", 16'h0000, 16'(timeout_flag));
    pulse_timeout();
    run(BTX_WATCHDOG_CLEAR, M, 10'h000, 1, 1'b0);
    chk("wdt_clear", 16'h0001, 16'(saw_clear));
    pulse_timeout();
    run(BTX_WATCHDOG_PRECLEAR_SECOND, M, 10'h000, 1, 1'b0);
    chk("timeout_flag", 16'h0001, 16'(timeout_flag));
    run(BTX_POWER_DOWN, M, 10'h000, 1, 1'b0);
    chk("flags", 16'h0001, {14'h0000, timeout_flag, power_down_flag});
    chk("wdt_clear", 16'h0001, 16'(saw_clear));
    chk("halted", 16'h0001, 16'(halted));
    repeat (3) @(negedge sys_clk);
    chk("ready", 16'h0000, 16'(instr_ready));
    @(posedge sys_clk);
    wake <= 1'b1;
    @(posedge sys_clk);
    wake <= 1'b0;
    run(BTX_WATCHDOG_PRECLEAR_FIRST, M, 10'h000, 1, 1'b0);
    chk("pdf", 16'h0001, 16'(power_down_flag));
    run(BTX_WATCHDOG_PRECLEAR_SECOND, M, 10'h000, 1, 1'b0);
    chk("pdf", 16'h0000, 16'(power_down_flag));
    $display("test watchdog done");
  endtask

  initial begin
    resetn = 1'b0;
    instr_valid = 1'b0;
    instr_op = BTX_NO_OPERATION;
    instr_addr = 6'h00;
    instr_bit = 3'h0;
    instr_imm = 8'h00;
    instr_target = 10'h000;
    table_ptr = 8'h00;
    wdt_timeout = 1'b0;
    wake = 1'b0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    t_branch();
    t_skips();
    t_pcl_table();
    t_watchdog();
    give_verdict();
  end
endmodule
